// ==== hdl/icw_ctrl.sv ====
/*
 Interrupt context and wake controller: shadow context, external edge
 requests, flag/enable/priority registers over AXI4-Lite, request and wake
 to the core. Assumes the core gives one instruction cycle per i_clk.
*/
// The AXI4-Lite interface to the registers was left to the implementer.
`include "icw_defs.svh"
module icw_ctrl #(
  parameter int ADDR_W = 18
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic [4:0] i_ext_request_inputs,
  input wire logic [47:0] i_src_events,
  input wire logic [3:0] i_cpu_priority_level,
  input wire logic i_sleep,
  input wire logic i_idle,
  input wire logic i_shadow_push,
  input wire logic i_shadow_pop,
  input wire logic [4:0] i_cpu_status_flags,
  input wire logic [63:0] i_work_regs,
  output logic o_shadow_restore,
  output icw_pkg::icw_ctx_t o_restore_ctx,
  output logic o_irq_req,
  output logic [5:0] o_irq_src,
  output icw_pkg::icw_level_t o_irq_level,
  output logic o_wake,
  output logic o_alt_vector,
  output logic o_nest_disable,
  output logic o_int
);
  import icw_pkg::*;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [15:0] PRI_IDX [11] = '{
    `ICW_IDX_PRI0, `ICW_IDX_PRI1, `ICW_IDX_PRI2, `ICW_IDX_PRI3,
    `ICW_IDX_PRI4, `ICW_IDX_PRI5, `ICW_IDX_PRI6, `ICW_IDX_PRI7,
    `ICW_IDX_PRI8, `ICW_IDX_PRI9, `ICW_IDX_PRI10};

  function automatic icw_word_t merge(input icw_word_t old,
                                      input logic [31:0] data,
                                      input logic [3:0] strb,
                                      input icw_word_t mask);
    icw_word_t lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}};
    return ((old & ~lanes) | (data[15:0] & lanes)) & mask;
  endfunction : merge

  function automatic icw_word_t pri_mask(input int k);
    return (k == 9) ? `ICW_MASK_PRI9 :
           (k == 10) ? `ICW_MASK_PRI10 : `ICW_MASK_PRI;
  endfunction : pri_mask

  function automatic icw_word_t pri_reset(input int k);
    return (k == 9) ? `ICW_RST_PRI9 :
           (k == 10) ? `ICW_RST_PRI10 : `ICW_RST_PRI;
  endfunction : pri_reset

  function automatic logic [47:0] ext_to_flags(input logic [4:0] e);
    logic [47:0] f;
    f = '0;
    f[`ICW_FLAG_EXT0] = e[0];
    f[`ICW_FLAG_EXT1] = e[1];
    f[`ICW_FLAG_EXT2] = e[2];
    f[`ICW_FLAG_EXT3] = e[3];
    f[`ICW_FLAG_EXT4] = e[4];
    return f;
  endfunction : ext_to_flags

  icw_wr_state_t wr_state_ff;
  logic aw_got_ff, w_got_ff, do_write;
  logic [15:0] wr_idx_ff;
  logic [31:0] wr_data_ff;
  logic [3:0] wr_strb_ff;
  logic wr_hit;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff, bresp_ff;
  icw_word_t rd_val;
  logic rd_hit;
  logic [15:0] rd_idx;

  icw_word_t trapctl_ff, vecedge_ff, stat_ff, mask_ff;
  icw_word_t [10:0] pri_ff;
  logic [47:0] flags_ff, nxt_flags, en_ff, nxt_en;
  icw_ctx_t ctx_ff;
  logic [4:0] ext_edge;
  logic req_now, wake_now;
  icw_word_t nxt_stat;

  icw_arb_if arb_if ();

  icw_arbiter u_arbiter (
    .arb(arb_if.arb)
  );

  icw_edge #(.N(5)) u_edge (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pins(i_ext_request_inputs),
    .i_polarity(vecedge_ff[4:0]),
    .o_edge(ext_edge)
  );

  // AXI4-Lite write: address and data in either order, then one response
  assign o_awready = (wr_state_ff == ICW_WR_IDLE) && !aw_got_ff;
  assign o_wready = (wr_state_ff == ICW_WR_IDLE) && !w_got_ff;
  assign do_write = (wr_state_ff == ICW_WR_IDLE) && aw_got_ff && w_got_ff;
  assign o_bvalid = wr_state_ff == ICW_WR_RESP;
  assign o_bresp = bresp_ff;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_state_ff <= ICW_WR_IDLE;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      wr_idx_ff <= '0;
      wr_data_ff <= '0;
      wr_strb_ff <= '0;
      bresp_ff <= RESP_OKAY;
    end else begin
      unique case (wr_state_ff)
        ICW_WR_IDLE: begin
          if (i_awvalid && o_awready) begin
            aw_got_ff <= 1'b1;
            wr_idx_ff <= 16'(i_awaddr[ADDR_W-1:2]);
          end
          if (i_wvalid && o_wready) begin
            w_got_ff <= 1'b1;
            wr_data_ff <= i_wdata;
            wr_strb_ff <= i_wstrb;
          end
          if (do_write) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            wr_state_ff <= ICW_WR_RESP;
          end
        end
        ICW_WR_RESP: begin
          if (i_bready) begin
            wr_state_ff <= ICW_WR_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    wr_hit = 1'b0;
    unique case (wr_idx_ff)
      `ICW_IDX_TRAPCTL, `ICW_IDX_VECEDGE, `ICW_IDX_FLG0, `ICW_IDX_FLG1,
      `ICW_IDX_FLG2, `ICW_IDX_EN0, `ICW_IDX_EN1, `ICW_IDX_EN2,
      `ICW_IDX_IRQSTAT, `ICW_IDX_IRQMASK: wr_hit = 1'b1;
      default: begin
        for (int k = 0; k < 11; k++) begin
          if (wr_idx_ff == PRI_IDX[k]) begin
            wr_hit = 1'b1;
          end
        end
      end
    endcase
  end

  // Read mux; the shadow context is deliberately absent from it
  assign rd_idx = 16'(i_araddr[ADDR_W-1:2]);

  always_comb begin
    rd_hit = 1'b1;
    rd_val = '0;
    unique case (rd_idx)
      `ICW_IDX_TRAPCTL: rd_val = trapctl_ff;
      `ICW_IDX_VECEDGE: rd_val = vecedge_ff;
      `ICW_IDX_FLG0: rd_val = flags_ff[15:0];
      `ICW_IDX_FLG1: rd_val = flags_ff[31:16];
      `ICW_IDX_FLG2: rd_val = flags_ff[47:32];
      `ICW_IDX_EN0: rd_val = en_ff[15:0];
      `ICW_IDX_EN1: rd_val = en_ff[31:16];
      `ICW_IDX_EN2: rd_val = en_ff[47:32];
      `ICW_IDX_IRQSTAT: rd_val = stat_ff;
      `ICW_IDX_IRQMASK: rd_val = mask_ff;
      default: begin
        rd_hit = 1'b0;
        for (int k = 0; k < 11; k++) begin
          if (rd_idx == PRI_IDX[k]) begin
            rd_hit = 1'b1;
            rd_val = pri_ff[k];
          end
        end
      end
    endcase
  end

  assign o_arready = !rvalid_ff;
  assign o_rvalid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_rresp = rresp_ff;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {16'h0000, rd_val};
      rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trapctl_ff <= `ICW_RST_ZERO;
      vecedge_ff <= `ICW_RST_ZERO;
      mask_ff <= `ICW_RST_ZERO;
    end else if (do_write) begin
      if (wr_idx_ff == `ICW_IDX_TRAPCTL) begin
        trapctl_ff <= merge(trapctl_ff, wr_data_ff, wr_strb_ff,
                            `ICW_MASK_TRAPCTL);
      end
      if (wr_idx_ff == `ICW_IDX_VECEDGE) begin
        vecedge_ff <= merge(vecedge_ff, wr_data_ff, wr_strb_ff,
                            `ICW_MASK_VECEDGE);
      end
      if (wr_idx_ff == `ICW_IDX_IRQMASK) begin
        mask_ff <= merge(mask_ff, wr_data_ff, wr_strb_ff, `ICW_MASK_IRQ);
      end
    end
  end

  assign o_alt_vector = vecedge_ff[`ICW_POS_ALTVEC];
  assign o_nest_disable = trapctl_ff[`ICW_POS_NEST];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < 11; k++) begin
        pri_ff[k] <= pri_reset(k);
      end
    end else if (do_write) begin
      for (int k = 0; k < 11; k++) begin
        if (wr_idx_ff == PRI_IDX[k]) begin
          pri_ff[k] <= merge(pri_ff[k], wr_data_ff, wr_strb_ff,
                             pri_mask(k));
        end
      end
    end
  end

  // Flags: a hardware event in the cycle of a software write still lands
  always_comb begin
    nxt_flags = flags_ff;
    nxt_en = en_ff;
    if (do_write) begin
      unique case (wr_idx_ff)
        `ICW_IDX_FLG0: nxt_flags[15:0] =
          merge(flags_ff[15:0], wr_data_ff, wr_strb_ff, 16'hFFFF);
        `ICW_IDX_FLG1: nxt_flags[31:16] =
          merge(flags_ff[31:16], wr_data_ff, wr_strb_ff, 16'hFFFF);
        `ICW_IDX_FLG2: nxt_flags[47:32] =
          merge(flags_ff[47:32], wr_data_ff, wr_strb_ff, 16'hFFFF);
        `ICW_IDX_EN0: nxt_en[15:0] =
          merge(en_ff[15:0], wr_data_ff, wr_strb_ff, 16'hFFFF);
        `ICW_IDX_EN1: nxt_en[31:16] =
          merge(en_ff[31:16], wr_data_ff, wr_strb_ff, 16'hFFFF);
        `ICW_IDX_EN2: nxt_en[47:32] =
          merge(en_ff[47:32], wr_data_ff, wr_strb_ff, 16'hFFFF);
        default: ;
      endcase
    end
    nxt_flags = (nxt_flags | i_src_events | ext_to_flags(ext_edge)) &
                `ICW_FLAG_IMPL;
    nxt_en = nxt_en & `ICW_FLAG_IMPL;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_ff <= '0;
      en_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
      en_ff <= nxt_en;
    end
  end

  // Pending requests and their levels go to the arbiter every cycle
  always_comb begin
    arb_if.pend = flags_ff[43:0] & en_ff[43:0];
    for (int i = 0; i < 44; i++) begin
      arb_if.lvl[i] = pri_ff[i / 4][(i % 4) * 4 +: 3];
    end
  end

  assign req_now = arb_if.found &&
    ({1'b0, arb_if.best_lvl} > i_cpu_priority_level);
  assign wake_now = req_now && (i_sleep || i_idle);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq_req <= 1'b0;
      o_irq_src <= '0;
      o_irq_level <= '0;
      o_wake <= 1'b0;
    end else begin
      o_irq_req <= req_now;
      o_irq_src <= arb_if.best_src;
      o_irq_level <= arb_if.best_lvl;
      o_wake <= wake_now;
    end
  end

  // Status: sticky, write one to clear, set beats clear
  always_comb begin
    nxt_stat = stat_ff;
    if (do_write && wr_idx_ff == `ICW_IDX_IRQSTAT) begin
      nxt_stat = stat_ff & ~(wr_data_ff[15:0] & {{8{wr_strb_ff[1]}},
                                                 {8{wr_strb_ff[0]}}});
    end
    nxt_stat[4:0] = nxt_stat[4:0] | ext_edge;
    nxt_stat[`ICW_POS_WAKE] = nxt_stat[`ICW_POS_WAKE] | (wake_now && !o_wake);
    nxt_stat = nxt_stat & `ICW_MASK_IRQ;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stat_ff <= `ICW_RST_ZERO;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  assign o_int = |(stat_ff & mask_ff);

  // Shadow context: one level, only the push and pop ports reach it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctx_ff <= '0;
    end else if (i_shadow_push) begin
      ctx_ff <= '{flags: i_cpu_status_flags, wregs: i_work_regs};
    end
  end

  // Pop in the same cycle as push returns the older copy
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_shadow_restore <= 1'b0;
      o_restore_ctx <= '0;
    end else begin
      o_shadow_restore <= i_shadow_pop;
      if (i_shadow_pop) begin
        o_restore_ctx <= ctx_ff;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_push_saves;
    i_shadow_push |=> ctx_ff == $past({i_cpu_status_flags, i_work_regs});
  endproperty
  a_push_saves: assert property (p_push_saves)
    else $error("shadow push did not capture context");

  property p_shadow_hold;
    !i_shadow_push |=> $stable(ctx_ff);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold)
    else $error("shadow changed without a push");

  property p_pop_restores;
    i_shadow_pop |=> o_shadow_restore && o_restore_ctx == $past(ctx_ff);
  endproperty
  a_pop_restores: assert property (p_pop_restores)
    else $error("shadow pop returned wrong context");

  property p_ext_sets_flag;
    ext_edge != '0 |=> (flags_ff & ext_to_flags($past(ext_edge))) ==
      ext_to_flags($past(ext_edge));
  endproperty
  a_ext_sets_flag: assert property (p_ext_sets_flag)
    else $error("external edge did not set its flag");

  property p_prio_reset;
    $rose(i_rst_n) |-> pri_ff[0] == `ICW_RST_PRI &&
      pri_ff[9] == `ICW_RST_PRI9 && pri_ff[10] == `ICW_RST_PRI10;
  endproperty
  a_prio_reset: assert property (p_prio_reset)
    else $error("priority reset value wrong");

  property p_pending_raises;
    (arb_if.found && {1'b0, arb_if.best_lvl} > i_cpu_priority_level)
      |=> o_irq_req ##0 o_irq_level == $past(arb_if.best_lvl);
  endproperty
  a_pending_raises: assert property (p_pending_raises)
    else $error("pending request not presented");

  property p_req_above_ipl;
    o_irq_req |-> {1'b0, o_irq_level} > $past(i_cpu_priority_level);
  endproperty
  a_req_above_ipl: assert property (p_req_above_ipl)
    else $error("request at or below core priority");

  property p_wake_with_req;
    o_wake == (o_irq_req && $past(i_sleep || i_idle));
  endproperty
  a_wake_with_req: assert property (p_wake_with_req)
    else $error("wake without request in low power");

  c_push_pop: cover property (i_shadow_push ##[1:20] i_shadow_pop);
  c_wake: cover property (i_sleep ##0 wake_now ##1 o_wake);
  c_ext_req: cover property (ext_edge[0] ##[1:10] o_irq_req);
endmodule : icw_ctrl

// ==== inc/icw_defs.svh ====
/*
 Register indices, field positions, reset values and write masks of the
 interrupt context and wake controller. Assumes the includer compiles it
 once per unit; the guard makes a second include harmless.
*/
`ifndef ICW_DEFS_SVH
`define ICW_DEFS_SVH

// Register indices; the byte address on the bus is four times the index
`define ICW_IDX_TRAPCTL 16'h0800
`define ICW_IDX_VECEDGE 16'h0082
`define ICW_IDX_FLG0 16'h0084
`define ICW_IDX_FLG1 16'h9800
`define ICW_IDX_FLG2 16'h0088
`define ICW_IDX_EN0 16'h008C
`define ICW_IDX_EN1 16'h008E
`define ICW_IDX_EN2 16'h0600
`define ICW_IDX_PRI0 16'h0094
`define ICW_IDX_PRI1 16'h9600
`define ICW_IDX_PRI2 16'h8600
`define ICW_IDX_PRI3 16'hA600
`define ICW_IDX_PRI4 16'h00AC
`define ICW_IDX_PRI5 16'h009E
`define ICW_IDX_PRI6 16'h00A0
`define ICW_IDX_PRI7 16'h00A2
`define ICW_IDX_PRI8 16'h00A4
`define ICW_IDX_PRI9 16'h00A6
`define ICW_IDX_PRI10 16'h00A8
`define ICW_IDX_IRQSTAT 16'h00B0
`define ICW_IDX_IRQMASK 16'h00B2

// Reset values
`define ICW_RST_ZERO 16'h0000
`define ICW_RST_PRI 16'h4444
`define ICW_RST_PRI9 16'h0444
`define ICW_RST_PRI10 16'h0440

// Writable bits
`define ICW_MASK_TRAPCTL 16'h8700
`define ICW_MASK_VECEDGE 16'h801F
`define ICW_MASK_PRI 16'h7777
`define ICW_MASK_PRI9 16'h0777
`define ICW_MASK_PRI10 16'h0770
`define ICW_MASK_IRQ 16'h003F
`define ICW_FLAG_IMPL 48'h067F_FFFF_FFFF

// Field positions
`define ICW_POS_ALTVEC 15
`define ICW_POS_NEST 15
`define ICW_POS_WAKE 5
`define ICW_FLAG_EXT0 0
`define ICW_FLAG_EXT1 16
`define ICW_FLAG_EXT2 23
`define ICW_FLAG_EXT3 36
`define ICW_FLAG_EXT4 37

`endif

// ==== inc/icw_pkg.sv ====
/*
 Types shared by the controller, its arbiter and edge detectors.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package icw_pkg;
  typedef logic [15:0] icw_word_t;
  typedef logic [2:0] icw_level_t;
  typedef enum logic [1:0] {
    ICW_WR_IDLE = 2'b01,
    ICW_WR_RESP = 2'b10
  } icw_wr_state_t;
  typedef struct packed {
    logic [4:0] flags;
    logic [63:0] wregs;
  } icw_ctx_t;
endpackage : icw_pkg

// ==== inc/icw_arb_if.sv ====
/*
 Carrier between the controller and its priority arbiter: pending sources
 and their levels out, the winning source back. Assumes one clock domain.
*/
interface icw_arb_if;
  import icw_pkg::*;
  logic [43:0] pend;
  icw_level_t [43:0] lvl;
  logic found;
  icw_level_t best_lvl;
  logic [5:0] best_src;
  modport ctrl (output pend, output lvl,
                input found, input best_lvl, input best_src);
  modport arb (input pend, input lvl,
               output found, output best_lvl, output best_src);
endinterface : icw_arb_if

// ==== hdl/icw_edge.sv ====
/*
 Synchronises the external request pins and detects the chosen edge.
 Assumes the pins are asynchronous to i_clk.
*/
module icw_edge #(
  parameter int N = 5
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [N-1:0] i_pins,
  input wire logic [N-1:0] i_polarity,
  output logic [N-1:0] o_edge
);
  import icw_pkg::*;
  logic [N-1:0] meta_ff, sync_ff, prev_ff;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= i_pins;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Polarity picks the direction without xoring the data, so flipping it
  // never fakes an edge
  assign o_edge = (i_polarity & prev_ff & ~sync_ff) |
                  (~i_polarity & ~prev_ff & sync_ff);

  property p_edge_needs_change;
    @(posedge i_clk) disable iff (!i_rst_n)
    (o_edge & ~(sync_ff ^ $past(sync_ff))) == '0 &&
    (o_edge & ~(i_polarity ^ sync_ff)) == '0;
  endproperty
  a_edge_needs_change: assert property (p_edge_needs_change)
    else $error("edge reported on a static level");
endmodule : icw_edge

// ==== hdl/icw_arbiter.sv ====
/*
 Picks the pending source with the highest level; on a tie the lowest
 source number wins. Purely combinational; the caller registers it.
*/
module icw_arbiter (
  icw_arb_if.arb arb
);
  import icw_pkg::*;

  always_comb begin
    arb.best_lvl = '0;
    arb.best_src = '0;
    // Level 0 can never win, so it acts as a source disable
    for (int i = 0; i < 44; i++) begin
      if (arb.pend[i] && arb.lvl[i] > arb.best_lvl) begin
        arb.best_lvl = arb.lvl[i];
        arb.best_src = 6'(i);
      end
    end
    arb.found = arb.best_lvl != '0;
  end
endmodule : icw_arbiter

// ==== bench/icw_core_model.sv ====
/*
 Core-side partner: drives context, priority level and low-power state,
 and issues shadow push and pop. Assumes calls start after a clock edge.
*/
module icw_core_model (
  input wire logic i_clk,
  input wire logic i_shadow_restore,
  input wire icw_pkg::icw_ctx_t i_restore_ctx,
  output logic o_push,
  output logic o_pop,
  output logic [4:0] o_flags,
  output logic [63:0] o_regs,
  output logic [3:0] o_ipl,
  output logic o_sleep,
  output logic o_idle
);
  timeunit 1ns;
  timeprecision 1ns;
  import icw_pkg::*;
  initial begin
    o_push = 1'b0;
    o_pop = 1'b0;
    o_flags = 5'h00;
    o_regs = 64'h0;
    o_ipl = 4'h0;
    o_sleep = 1'b0;
    o_idle = 1'b0;
  end
  task automatic set_core(input logic [3:0] cpu_priority_level, input logic s,
                          input logic d);
    @(posedge i_clk);
    o_ipl <= cpu_priority_level;
    o_sleep <= s;
    o_idle <= d;
  endtask : set_core
  // Push and pop only ever come from one handler level
  task automatic push(input logic [4:0] f, input logic [63:0] r);
    @(posedge i_clk);
    o_flags <= f;
    o_regs <= r;
    o_push <= 1'b1;
    @(posedge i_clk);
    o_push <= 1'b0;
    // Live context moves on so a stale copy cannot pass
    o_flags <= ~f;
    o_regs <= ~r;
  endtask : push
  task automatic pop(output icw_ctx_t c, output logic ok);
    int n;
    @(posedge i_clk);
    o_pop <= 1'b1;
    @(posedge i_clk);
    o_pop <= 1'b0;
    for (n = 0; n < 4; n++) begin
      @(posedge i_clk);
      if (i_shadow_restore) break;
    end
    ok = i_shadow_restore;
    c = i_restore_ctx;
  endtask : pop
endmodule : icw_core_model

// ==== bench/tb_top.sv ====
/*
 Self-checking bench: register, edge, priority, wake and shadow tests.
 Assumes the controller, its package and register defines are compiled.
*/
`include "icw_defs.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import icw_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [17:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [4:0] ext = '0, flags;
  logic [47:0] ev = '0;
  logic push, pop, slp, idl, restore, irq, wake, alt, nest, int_o, ok;
  logic [63:0] regs;
  logic [3:0] cpu_priority_level;
  logic [5:0] irq_src;
  icw_level_t irq_lvl;
  icw_ctx_t ctx, c;
  logic [15:0] b;
  logic [15:0] freg [3] = '{`ICW_IDX_FLG0, `ICW_IDX_FLG1, `ICW_IDX_FLG2};
  int fpos [5] = '{0, 16, 23, 36, 37};
  int fails = 0, tests_run = 0, cyc = 0, i, n;

  icw_ctrl dut (.i_clk(clk), .i_rst_n(rst_n), .i_awvalid(awvalid),
    .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
    .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
    .o_rresp(rresp), .i_ext_request_inputs(ext), .i_src_events(ev),
    .i_cpu_priority_level(cpu_priority_level), .i_sleep(slp), .i_idle(idl),
    .i_shadow_push(push), .i_shadow_pop(pop),
    .i_cpu_status_flags(flags), .i_work_regs(regs),
    .o_shadow_restore(restore), .o_restore_ctx(ctx), .o_irq_req(irq),
    .o_irq_src(irq_src), .o_irq_level(irq_lvl), .o_wake(wake),
    .o_alt_vector(alt), .o_nest_disable(nest), .o_int(int_o));

  icw_core_model u_core (.i_clk(clk), .i_shadow_restore(restore),
    .i_restore_ctx(ctx), .o_push(push), .o_pop(pop), .o_flags(flags),
    .o_regs(regs), .o_ipl(cpu_priority_level), .o_sleep(slp), .o_idle(idl));

  always #50 clk = ~clk;

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // A hung handshake lands here instead of running forever
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic wr(input logic [15:0] idx, input logic [15:0] d);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic chk_rd(input logic [15:0] idx, input logic [31:0] e);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    `CHK(rd, e)
  endtask : chk_rd

  task automatic pulse(input logic [47:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= '0;
    repeat (4) @(posedge clk);
  endtask : pulse

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    chk_rd(`ICW_IDX_PRI0, 32'h0000_4444);
    chk_rd(`ICW_IDX_PRI8, 32'h0000_4444);
    chk_rd(`ICW_IDX_PRI9, 32'h0000_0444);
    chk_rd(`ICW_IDX_PRI10, 32'h0000_0440);
    chk_rd(`ICW_IDX_VECEDGE, 32'h0000_0000);
    chk_rd(16'h0001, 32'h0000_0000);
    `CHK(resp, 2'b10)
    wr(16'h0001, 16'hFFFF);
    `CHK(resp, 2'b10)
    wr(`ICW_IDX_TRAPCTL, 16'hFFFF);
    chk_rd(`ICW_IDX_TRAPCTL, 32'h0000_8700);
    `CHK(nest, 1'b1)
    // Shadow holds one copy; the second save wins
    u_core.push(5'h15, 64'h1111_2222_3333_4444);
    u_core.push(5'h0A, 64'hA5A5_5A5A_0F0F_F0F0);
    u_core.pop(c, ok);
    `CHK(ok, 1'b1)
    `CHK(c, {5'h0A, 64'hA5A5_5A5A_0F0F_F0F0})
    for (i = 0; i < 5; i++) begin
      b = 16'h0001 << (fpos[i] % 16);
      wr(`ICW_IDX_VECEDGE, 16'h8000);
      `CHK(alt, 1'b1)
      @(posedge clk);
      ext[i] <= 1'b1;
      repeat (6) @(posedge clk);
      chk_rd(freg[fpos[i] / 16], {16'h0000, b});
      wr(freg[fpos[i] / 16], 16'h0000);
      repeat (6) @(posedge clk);
      chk_rd(freg[fpos[i] / 16], 32'h0000_0000);
      wr(`ICW_IDX_VECEDGE, 16'h0001 << i);
      @(posedge clk);
      ext[i] <= 1'b0;
      repeat (6) @(posedge clk);
      chk_rd(freg[fpos[i] / 16], {16'h0000, b});
      wr(freg[fpos[i] / 16], 16'h0000);
    end
    wr(`ICW_IDX_FLG2, 16'hFFFF);
    chk_rd(`ICW_IDX_FLG2, 32'h0000_067F);
    wr(`ICW_IDX_FLG2, 16'h0000);
    chk_rd(`ICW_IDX_IRQSTAT, 32'h0000_001F);
    `CHK(int_o, 1'b0)
    wr(`ICW_IDX_IRQMASK, 16'h0010);
    `CHK(int_o, 1'b1)
    wr(`ICW_IDX_IRQSTAT, 16'h000F);
    `CHK(int_o, 1'b1)
    wr(`ICW_IDX_IRQSTAT, 16'h0010);
    `CHK(int_o, 1'b0)
    chk_rd(`ICW_IDX_IRQSTAT, 32'h0000_0000);
    // Source 1 sits at the reset level 4
    wr(`ICW_IDX_EN0, 16'h0002);
    u_core.set_core(4'h4, 1'b0, 1'b0);
    pulse(48'h2);
    `CHK(irq, 1'b0)
    u_core.set_core(4'h3, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b1)
    `CHK(irq_src, 6'h01)
    `CHK(irq_lvl, 3'h4)
    `CHK(wake, 1'b0)
    wr(`ICW_IDX_FLG0, 16'h0000);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    wr(`ICW_IDX_EN0, 16'h0000);
    pulse(48'h2);
    `CHK(irq, 1'b0)
    wr(`ICW_IDX_FLG0, 16'h0000);
    wr(`ICW_IDX_EN0, 16'h0002);
    for (i = 0; i < 2; i++) begin
      u_core.set_core(4'h3, i == 0, i == 1);
      pulse(48'h2);
      for (n = 0; n < 10 && irq !== 1'b1; n++) @(posedge clk);
      `CHK(wake, 1'b1)
      `CHK(irq, 1'b1)
      wr(`ICW_IDX_FLG0, 16'h0000);
      u_core.set_core(4'h3, 1'b0, 1'b0);
    end
    chk_rd(`ICW_IDX_IRQSTAT, 32'h0000_0020);
    report_and_stop();
  end
endmodule : tb_top
